// >>> design/qbs_ctl.sv
// controller end: issues four-word bursts to the burst memory
// Notes on behaviour
// [R1] bypass high: first word 1.5 cycles later
// [R2] bypass low: first word one cycle later
// [R3] each address moves four consecutive words
// [R4] shared address bus, reads and writes alternate
// [R5] one word on every rising clock edge
// [R6] read and write ports run independently
// [R7] inputs captured on input clock edges
// [R8] read data launched from output registers
// [R9] each port has its own select
// [R10] writes self-timed, no further strobes needed
// [R11] echo clocks travel with read data
// [R12] read returns newest written data
// [R13] deasserted select leaves port idle
// assumes: sys_clk is the user domain; link clock derived here
`timescale 1ns/100ps
`default_nettype none
module qbs_ctl (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_b,
    input  wire logic                         bypass_mode,
    input  wire logic                         wr_valid,
    output var  logic                         wr_ready,
    input  wire logic [qbs_pkg::ADDR_W-1:0]   wr_addr,
    input  wire logic [4*qbs_pkg::WORD_W-1:0] wr_data,
    input  wire logic                         rd_valid,
    output var  logic                         rd_ready,
    input  wire logic [qbs_pkg::ADDR_W-1:0]   rd_addr,
    output var  logic                         rdo_valid,
    input  wire logic                         rdo_ready,
    output var  logic [qbs_pkg::WORD_W-1:0]   rdo_data,
    qbs_link_if.ctl                           link
);
    // ---------------------------------------------------------------
    // link clock divider
    // ---------------------------------------------------------------
    logic                       lclk_r;
    logic                       lrst_b_r;
    logic                       wsel_b_r;
    logic                       rsel_b_r;
    logic [qbs_pkg::ADDR_W-1:0] addr_r;
    logic [qbs_pkg::WORD_W-1:0] wd_r;
    logic                       bypass_r;
    // launch on the falling half so the memory samples a stable bus
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            lclk_r <= 1'b0;
        end else begin
            lclk_r <= ~lclk_r;
        end
    end
    // memory end resets on the first link rising edge after release
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            lrst_b_r <= 1'b0;
        end else if (lclk_r) begin
            lrst_b_r <= 1'b1;
        end
    end
    assign link.link_rst_b          = lrst_b_r;
    assign link.link_clk            = lclk_r;
    assign link.link_clk_b          = ~lclk_r;
    assign link.write_port_select_b = wsel_b_r;
    assign link.read_port_select_b  = rsel_b_r;
    assign link.addr                = addr_r;
    assign link.wdata               = wd_r;
    assign link.pll_bypass          = bypass_r;

    // ---------------------------------------------------------------
    // command sequencer
    // ---------------------------------------------------------------
    qbs_pkg::qbs_phase_t         phase_r;
    logic [qbs_pkg::BEAT_W-1:0]  beat_r;
    logic [4*qbs_pkg::WORD_W-1:0] wbuf_r;
    logic                        last_wr_r;
    logic [2:0]                  out_cnt_r;
    logic                        launch;
    logic                        do_wr;
    logic                        do_rd;
    logic                        fifo_room;
    // change the link only as the link clock falls, never with its rise
    assign launch = lclk_r;
    // [R4] alternate when both pending
    assign do_wr = wr_valid && (!rd_valid || !last_wr_r);
    // reads stall until the previous burst has fully drained and the two-entry return buffer is empty
    assign do_rd = rd_valid && !do_wr && fifo_room && out_cnt_r == 3'h0;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            phase_r   <= qbs_pkg::QBS_IDLE;
            beat_r    <= '0;
            wsel_b_r  <= 1'b1;
            rsel_b_r  <= 1'b1;
            addr_r    <= '0;
            wd_r      <= '0;
            wbuf_r    <= '0;
            last_wr_r <= 1'b0;
            wr_ready  <= 1'b0;
            rd_ready  <= 1'b0;
            bypass_r  <= 1'b0;
        end else begin
            wr_ready <= 1'b0;
            rd_ready <= 1'b0;
            if (launch) begin
                bypass_r <= bypass_mode;
                unique case (phase_r)
                    qbs_pkg::QBS_IDLE: begin
                        wsel_b_r <= 1'b1;
                        rsel_b_r <= 1'b1;
                        // [R9] [R13] only the used select asserted
                        if (do_wr && !wr_ready) begin
                            phase_r   <= qbs_pkg::QBS_WRITE;
                            wsel_b_r  <= 1'b0;
                            addr_r    <= wr_addr;
                            wbuf_r    <= wr_data;
                            wr_ready  <= 1'b1;
                            last_wr_r <= 1'b1;
                            beat_r    <= '0;
                        end else if (do_rd && !rd_ready) begin
                            phase_r   <= qbs_pkg::QBS_READ;
                            rsel_b_r  <= 1'b0;
                            addr_r    <= rd_addr;
                            rd_ready  <= 1'b1;
                            last_wr_r <= 1'b0;
                            beat_r    <= '0;
                        end
                    end
                    qbs_pkg::QBS_WRITE: begin
                        // [R3] [R5] [R10] four words, no extra strobe
                        wsel_b_r <= 1'b1;
                        wd_r     <= wbuf_r[qbs_pkg::WORD_W-1:0];
                        wbuf_r   <= wbuf_r >> qbs_pkg::WORD_W;
                        beat_r   <= beat_r + 1'b1;
                        if (beat_r == qbs_pkg::BEAT_LAST) begin
                            phase_r <= qbs_pkg::QBS_IDLE;
                        end
                    end
                    qbs_pkg::QBS_READ: begin
                        rsel_b_r <= 1'b1;
                        beat_r   <= beat_r + 1'b1;
                        if (beat_r == qbs_pkg::BEAT_LAST) begin
                            phase_r <= qbs_pkg::QBS_IDLE;
                        end
                    end
                    default: begin
                        phase_r <= qbs_pkg::QBS_IDLE;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // read capture, then two-entry return buffer
    // ---------------------------------------------------------------
    // link clock comes from sys_clk: memory outputs move just after a link
    // rise, so the next sys edge (link falling half) sees them settled
    logic                       seen_r;
    logic                       in_valid;
    logic [qbs_pkg::WORD_W-1:0] cap_r [qbs_pkg::BURST];
    logic [2:0]                 fill_r;
    logic [2:0]                 drain_r;
    logic [qbs_pkg::WORD_W-1:0] spare_r;
    logic                       spare_valid_r;
    logic                       push;
    logic                       pop;
    // [R11] each echo change marks one word
    assign in_valid  = lclk_r && (link.returned_strobe != seen_r);
    assign push      = (drain_r != fill_r) && !spare_valid_r;
    assign pop       = rdo_valid && rdo_ready;
    assign fifo_room = !spare_valid_r && !rdo_valid;
    // the memory cannot stall, so a whole burst is held here
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            seen_r  <= 1'b0;
            fill_r  <= '0;
            drain_r <= '0;
        end else begin
            if (lclk_r) begin
                seen_r <= link.returned_strobe;
            end
            if (rd_ready) begin
                fill_r  <= '0;
                drain_r <= '0;
            end else begin
                if (in_valid && fill_r != 3'(qbs_pkg::BURST)) begin
                    fill_r <= fill_r + 3'h1;
                end
                if (push) begin
                    drain_r <= drain_r + 3'h1;
                end
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (in_valid && fill_r != 3'(qbs_pkg::BURST)) begin
            cap_r[fill_r[1:0]] <= link.rdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdo_valid     <= 1'b0;
            rdo_data      <= '0;
            spare_valid_r <= 1'b0;
            spare_r       <= '0;
            out_cnt_r     <= '0;
        end else begin
            if (!rdo_valid || pop) begin
                if (spare_valid_r) begin
                    rdo_data      <= spare_r;
                    rdo_valid     <= 1'b1;
                    spare_valid_r <= 1'b0;
                end else if (push) begin
                    rdo_data  <= cap_r[drain_r[1:0]];
                    rdo_valid <= 1'b1;
                end else begin
                    rdo_valid <= 1'b0;
                end
            end else if (push) begin
                spare_r       <= cap_r[drain_r[1:0]];
                spare_valid_r <= 1'b1;
            end
            // track a burst in flight until all four words drain
            if (rd_ready) begin
                out_cnt_r <= 3'(qbs_pkg::BURST);
            end else if (pop && out_cnt_r != 3'h0) begin
                out_cnt_r <= out_cnt_r - 3'h1;
            end
        end
    end
endmodule : qbs_ctl
`default_nettype wire

// >>> design/qbs_pkg.sv
// package for the quad-rate four-word burst memory port
// assumes: shared by the link interface, the memory end and the controller end
package qbs_pkg;
    // ---------------------------------------------------------------
    // widths and sizes
    // ---------------------------------------------------------------
    localparam int WORD_W  = 18;
    localparam int ADDR_W  = 6;
    localparam int BURST   = 4;
    localparam int DEPTH   = 64;
    localparam int BEAT_W  = 2;
    // ---------------------------------------------------------------
    // timing: latencies in link clock edges (both clock rails counted), CLK_DIV in sys_clk cycles per link edge
    // ---------------------------------------------------------------
    localparam int LAT_BYPASS_EDGES = 3;
    localparam int LAT_PLL_EDGES    = 2;
    localparam int SYNC_STAGES      = 3;
    localparam int CLK_DIV          = 2;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;

    typedef enum logic [1:0] {
        QBS_IDLE  = 2'b00,
        QBS_WRITE = 2'b01,
        QBS_READ  = 2'b10
    } qbs_phase_t;
endpackage : qbs_pkg

// >>> design/qbs_link_if.sv
// link between the memory controller and the burst memory
// assumes: controller makes link_clk and its complement; memory returns an echo pair that toggles only with read words
`timescale 1ns/100ps
`default_nettype none
interface qbs_link_if;
    logic                         link_clk;
    logic                         link_clk_b;
    logic                         link_rst_b;
    logic                         write_port_select_b;
    logic                         read_port_select_b;
    logic [qbs_pkg::ADDR_W-1:0]   addr;
    logic [qbs_pkg::WORD_W-1:0]   wdata;
    logic [qbs_pkg::WORD_W-1:0]   rdata;
    logic                         returned_strobe;
    logic                         returned_strobe_b;
    logic                         pll_bypass;

    modport mem (
        input  link_clk, link_clk_b, link_rst_b, write_port_select_b,
               read_port_select_b, addr, wdata, pll_bypass,
        output rdata, returned_strobe, returned_strobe_b
    );
    modport ctl (
        output link_clk, link_clk_b, link_rst_b, write_port_select_b,
               read_port_select_b, addr, wdata, pll_bypass,
        input  rdata, returned_strobe, returned_strobe_b
    );
endinterface : qbs_link_if
`default_nettype wire

// >>> design/qbs_mem.sv
// memory end of the four-word burst port
// assumes: link_clk is a 2x clock, one edge per data word; each rising
// edge of the true or complement rail maps to one rising edge here
`timescale 1ns/100ps
`default_nettype none
module qbs_mem (
    qbs_link_if.mem link
);
    // ---------------------------------------------------------------
    // input registers and beat phase
    // ---------------------------------------------------------------
    logic [qbs_pkg::WORD_W-1:0] mem_r [qbs_pkg::DEPTH*qbs_pkg::BURST];
    logic [qbs_pkg::BEAT_W-1:0] wbeat_r;
    logic [qbs_pkg::BEAT_W-1:0] rbeat_r;
    logic                       wact_r;
    logic                       ract_r;
    logic [qbs_pkg::ADDR_W-1:0] waddr_r;
    logic [qbs_pkg::ADDR_W-1:0] raddr_r;
    logic [qbs_pkg::WORD_W-1:0] rdata_r;
    logic                       vnxt;
    logic [2:0]                 rpipe_r;
    logic                       strobe_r;

    // [R7] captured inputs; [R13] deasserted select starts nothing
    always_ff @(posedge link.link_clk) begin
        if (!link.link_rst_b) begin
            wact_r  <= 1'b0;
            waddr_r <= '0;
            wbeat_r <= '0;
        end else if (!link.write_port_select_b && !wact_r) begin
            wact_r  <= 1'b1;
            waddr_r <= link.addr;
            wbeat_r <= '0;
        end else if (wact_r) begin
            wbeat_r <= wbeat_r + 1'b1;
            if (wbeat_r == qbs_pkg::BEAT_LAST) begin
                wact_r <= 1'b0;
            end
        end
    end

    // [R10] self-timed write, one word per edge
    always_ff @(posedge link.link_clk) begin
        if (wact_r) begin
            mem_r[{waddr_r, wbeat_r}] <= link.wdata;
        end
    end

    // [R4] [R6] read address taken independently of write
    always_ff @(posedge link.link_clk) begin
        if (!link.link_rst_b) begin
            ract_r  <= 1'b0;
            raddr_r <= '0;
            rbeat_r <= '0;
        end else if (!link.read_port_select_b && !ract_r) begin
            ract_r  <= 1'b1;
            raddr_r <= link.addr;
            rbeat_r <= '0;
        end else if (ract_r) begin
            rbeat_r <= rbeat_r + 1'b1;
            if (rbeat_r == qbs_pkg::BEAT_LAST) begin
                ract_r <= 1'b0;
            end
        end
    end

    // [R12] forward a word being written this edge
    always_ff @(posedge link.link_clk) begin
        if (!link.link_rst_b) begin
            rpipe_r <= '0;
            rdata_r <= '0;
        end else begin
            rpipe_r <= {rpipe_r[1:0], ract_r};
            if (ract_r) begin
                rdata_r <= (wact_r && {waddr_r, wbeat_r} == {raddr_r, rbeat_r})
                           ? link.wdata : mem_r[{raddr_r, rbeat_r}];
            end
        end
    end

    // ---------------------------------------------------------------
    // output registers
    // ---------------------------------------------------------------
    logic [qbs_pkg::WORD_W-1:0] d1_r;
    logic [qbs_pkg::WORD_W-1:0] out_r;
    // [R1] [R2] latency picked by bypass pin; [R8] output register
    assign vnxt = link.pll_bypass ? rpipe_r[1] : rpipe_r[0];
    always_ff @(posedge link.link_clk) begin
        if (!link.link_rst_b) begin
            d1_r     <= '0;
            out_r    <= '0;
            strobe_r <= 1'b0;
        end else begin
            d1_r     <= rdata_r;
            out_r    <= link.pll_bypass ? d1_r : rdata_r;
            // [R11] echo changes with each live word, same edge
            strobe_r <= vnxt ? ~strobe_r : 1'b0;
        end
    end

    // [R5] [R3] one word each edge, four per burst
    assign link.rdata             = out_r;
    assign link.returned_strobe   = strobe_r;
    assign link.returned_strobe_b = ~strobe_r;
endmodule : qbs_mem
`default_nettype wire

// >>> dv/qbs_properties.sv
// checker for the link between controller and burst memory
// assumes: instantiated in tb beside the link interface, sys_clk sampling
`timescale 1ns/100ps
`default_nettype none
module qbs_properties (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic link_clk_b,
    input wire logic write_port_select_b,
    input wire logic read_port_select_b,
    input wire logic returned_strobe,
    input wire logic returned_strobe_b
);
    // ---------------------------------------------------------------
    // warm-up: memory end resets only on a link clock edge, echo pair settles late
    // ---------------------------------------------------------------
    logic [3:0] warm_cnt_r;
    logic       warm;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            warm_cnt_r <= 4'h0;
        end else if (warm_cnt_r != 4'hf) begin
            warm_cnt_r <= warm_cnt_r + 4'h1;
        end
    end
    assign warm = (warm_cnt_r == 4'hf);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence wr_start_s; $fell(write_port_select_b); endsequence
    sequence rd_start_s; $fell(read_port_select_b); endsequence

    chk_clk_compl: assert property (link_clk_b == ~link_clk)
        else $error("link clock rails not complementary");
    chk_clk_toggle: assert property ($past(rst_b) |-> link_clk != $past(link_clk))
        else $error("link clock missed an edge");
    chk_echo_compl: assert property (warm |-> returned_strobe_b == ~returned_strobe)
        else $error("echo pair not complementary");
    chk_echo_toggle: assert property (rd_start_s |-> ##[4:16] $changed(returned_strobe))
        else $error("echo clock did not follow a read");
    chk_sel_exclusive: assert property (!(!write_port_select_b && !read_port_select_b))
        else $error("both port selects on one edge");
    chk_wr_burst_gap: assert property (wr_start_s |=> !write_port_select_b ##1 write_port_select_b[*7])
        else $error("write select inside a burst");
    chk_rd_burst_gap: assert property (rd_start_s |=> !read_port_select_b ##1 read_port_select_b[*7])
        else $error("read select inside a burst");
    chk_reset_idle: assert property (disable iff (1'b0) !rst_b |=> write_port_select_b && read_port_select_b)
        else $error("port select active during reset");
endmodule : qbs_properties
`default_nettype wire

// >>> dv/tb.sv
// testbench: controller and memory ends joined by the link interface
// assumes: sys_clk 100 ns, link clock derived inside the controller
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int AW = qbs_pkg::ADDR_W;
    localparam int WW = qbs_pkg::WORD_W;
    logic          sys_clk;
    logic          rst_b;
    logic          bypass_mode;
    logic          wr_valid;
    logic          wr_ready;
    logic [AW-1:0] wr_addr;
    logic [4*WW-1:0] wr_data;
    logic          rd_valid;
    logic          rd_ready;
    logic [AW-1:0] rd_addr;
    logic          rdo_valid;
    logic          rdo_ready;
    logic [WW-1:0] rdo_data;
    int            num_errors;
    int            checks_done;
    int            lat_b;
    int            lat_p;

    qbs_link_if qbs_link_if_inst ();
    qbs_ctl qbs_ctl_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .bypass_mode(bypass_mode), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_addr(rd_addr), .rdo_valid(rdo_valid),
        .rdo_ready(rdo_ready), .rdo_data(rdo_data), .link(qbs_link_if_inst));
    qbs_mem qbs_mem_inst (.link(qbs_link_if_inst));
    qbs_properties qbs_properties_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .link_clk(qbs_link_if_inst.link_clk),
        .link_clk_b(qbs_link_if_inst.link_clk_b),
        .write_port_select_b(qbs_link_if_inst.write_port_select_b),
        .read_port_select_b(qbs_link_if_inst.read_port_select_b),
        .returned_strobe(qbs_link_if_inst.returned_strobe),
        .returned_strobe_b(qbs_link_if_inst.returned_strobe_b));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [4*WW-1:0] got, input logic [4*WW-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic send_write(input logic [AW-1:0] a, input logic [4*WW-1:0] d);
        int n;
        @(negedge sys_clk);
        wr_valid = 1'b1;
        wr_addr  = a;
        wr_data  = d;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (wr_ready !== 1'b1 && n < 200);
        wr_valid = 1'b0;
        check({71'h0, wr_ready}, 72'h1);
    endtask : send_write

    // stall holds the receiver off so the two-entry buffer fills
    task automatic send_read(input logic [AW-1:0] a, input logic [4*WW-1:0] exp,
                             input bit stall, output int lat);
        logic [4*WW-1:0] got;
        int n;
        @(negedge sys_clk);
        rd_valid  = 1'b1;
        rd_addr   = a;
        rdo_ready = !stall;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (rd_ready !== 1'b1 && n < 200);
        rd_valid = 1'b0;
        lat = 0;
        while (rdo_valid !== 1'b1 && lat < 200) begin @(negedge sys_clk); lat++; end
        if (stall) begin
            repeat (20) @(negedge sys_clk);
            check({71'h0, rdo_valid}, 72'h1);
            rdo_ready = 1'b1;
        end
        for (int k = 0; k < 4; k++) begin
            n = 0;
            while (rdo_valid !== 1'b1 && n < 200) begin @(negedge sys_clk); n++; end
            got[k*WW +: WW] = rdo_data;
            @(negedge sys_clk);
        end
        check(got, exp);
    endtask : send_read

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_bypass();
        bypass_mode = 1'b1;
        send_write(6'h05, 72'h12_3456_789a_bcde_f012);
        send_read(6'h05, 72'h12_3456_789a_bcde_f012, 1'b0, lat_b);
    endtask : t_bypass

    task automatic t_plain();
        bypass_mode = 1'b0;
        repeat (8) @(negedge sys_clk);
        send_write(6'h3f, 72'hfe_dcba_9876_5432_10ab);
        send_read(6'h3f, 72'hfe_dcba_9876_5432_10ab, 1'b0, lat_p);
        check(72'(lat_b - lat_p), 72'((qbs_pkg::LAT_BYPASS_EDGES
            - qbs_pkg::LAT_PLL_EDGES) * qbs_pkg::CLK_DIV));
    endtask : t_plain

    task automatic t_coherent_stall();
        int l;
        send_write(6'h00, 72'h3c_5a5a_a5a5_0f0f_f0f0);
        send_read(6'h00, 72'h3c_5a5a_a5a5_0f0f_f0f0, 1'b1, l);
        send_read(6'h05, 72'h12_3456_789a_bcde_f012, 1'b0, l);
    endtask : t_coherent_stall

    task automatic t_concurrent();
        int l;
        fork
            send_write(6'h01, 72'h00_1111_2222_3333_4444);
            send_read(6'h3f, 72'hfe_dcba_9876_5432_10ab, 1'b0, l);
        join
        send_read(6'h01, 72'h00_1111_2222_3333_4444, 1'b0, l);
    endtask : t_concurrent

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        finish_test();
    end

    initial begin
        rst_b       = 1'b0;
        bypass_mode = 1'b1;
        wr_valid    = 1'b0;
        wr_addr     = 6'h00;
        wr_data     = 72'h0;
        rd_valid    = 1'b0;
        rd_addr     = 6'h00;
        rdo_ready   = 1'b1;
        num_errors  = 0;
        checks_done = 0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (20) @(negedge sys_clk);
        t_bypass();
        t_plain();
        t_coherent_stall();
        t_concurrent();
        finish_test();
    end
endmodule : tb
`default_nettype wire
